// [rtl/sosg_pkg.sv]
package sosg_pkg;
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int TW = 64;
  localparam int OFS_W = 32;
  localparam int SLEW_W = 24;
  localparam int LAT_W = 16;
  localparam int MAG_W = 20;
  // Threshold LSB is 2^-40 s, offsets are kept in 2^-48 s
  localparam int MAG_SHIFT = 8;
  localparam logic [AW-1:0] A_OFS = 16'h0d30;
  localparam logic [AW-1:0] A_SLEW = 16'h0d34;
  localparam logic [AW-1:0] A_LAT = 16'h0d37;
  localparam logic [AW-1:0] A_MAG = 16'h0d39;
  localparam logic [AW-1:0] A_BYP = 16'h0d3c;
  localparam logic [AW-1:0] A_STAT = 16'h0d40;
  localparam logic [AW-1:0] A_RST = 16'h0f08;
  localparam logic [AW-1:0] A_TLO = 16'h0f0a;
  localparam logic [AW-1:0] A_THI = 16'h0f0e;
  localparam logic [AW-1:0] A_UPD = 16'h000f;
  localparam logic [AW-1:0] A_IRQ = 16'h301d;
  localparam int ST_ERR = 7;
  localparam int ST_SLEW = 6;
  localparam int ST_RDY = 2;
  localparam int IRQ_RDY = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_SST = 2;
  localparam int IRQ_SEND = 3;
  localparam int RST_BIT = 0;
  localparam int BYP_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam longint CLK_HZ = 50_000_000;
  // Latency LSB is 1/65536 s; slew steps once per 1/4096 s so one step = limit in 2^-48 s
  localparam longint LAT_LSB_PER_S = 65536;
  localparam longint SLEW_TICK_PER_S = 4096;
  localparam int LAT_TICK_CYC = int'(CLK_HZ / LAT_LSB_PER_S);
  localparam int SLEW_TICK_CYC = int'(CLK_HZ / SLEW_TICK_PER_S);
  localparam int FILT_MAX = 6;
  typedef enum logic [0:0] {
    SOSG_IDLE = 1'b0,
    SOSG_WAIT = 1'b1
  } sosg_evt_t;
endpackage : sosg_pkg

// [rtl/sosg_top.sv]
`timescale 1ns/10ps
module sosg_top
  import sosg_pkg::*;
#(
  parameter int FILT_LEVELS = FILT_MAX,
  parameter int SLEW_TICK = SLEW_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  input wire logic sync_event,
  input wire logic [TW-1:0] local_time,
  input wire logic sysclk_pll_stable,
  input wire logic ccdpll_locked,
  input wire logic ccr_switch,
  output logic [TW-1:0] common_time,
  output logic mfp_slewing,
  output logic mfp_sync_error,
  output logic mfp_ready
);
  localparam int LVL_W = $clog2(FILT_LEVELS + 1);
  localparam int TK_W = $clog2(SLEW_TICK + 1);
  localparam int LD_W = $clog2(LAT_TICK_CYC + 1);

  function automatic logic [TW-1:0] f_abs(input logic [TW-1:0] x);
    f_abs = x[TW-1] ? TW'(-x) : x;
  endfunction : f_abs

  logic rst_meta_q, rst_n_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [OFS_W-1:0] ofs_q;
  logic [SLEW_W-1:0] slew_q;
  logic [LAT_W-1:0] lat_q;
  logic [MAG_W-1:0] mag_q;
  logic byp_q;
  logic [DW-1:0] tlo_q, thi_q;
  logic wr_ofs, wr_slew, wr_rst, upd;
  assign wr_ofs = wr_en && addr == A_OFS;
  assign wr_slew = wr_en && addr == A_SLEW;
  assign wr_rst = wr_en && addr == A_RST && wr_data[RST_BIT];
  assign upd = wr_en && addr == A_UPD && wr_data[UPD_BIT];

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ofs_q <= '0;
      slew_q <= '0;
      lat_q <= '0;
      mag_q <= '0;
      byp_q <= 1'b0;
      tlo_q <= '0;
      thi_q <= '0;
    end else if (wr_en) begin
      if (wr_ofs) ofs_q <= wr_data;
      if (wr_slew) slew_q <= wr_data[SLEW_W-1:0];
      if (addr == A_LAT) lat_q <= wr_data[LAT_W-1:0];
      if (addr == A_MAG) mag_q <= wr_data[MAG_W-1:0];
      if (addr == A_BYP) byp_q <= wr_data[BYP_BIT];
      if (addr == A_TLO) tlo_q <= wr_data;
      if (addr == A_THI) thi_q <= wr_data;
    end
  end

  // Event capture; a new event in the same cycle as an update starts a fresh wait
  sosg_evt_t st_q;
  logic [TW-1:0] evt_q;
  logic pending, lat_exp;
  logic [LD_W-1:0] ldiv_q;
  logic [LAT_W-1:0] lcnt_q;
  assign pending = st_q == SOSG_WAIT;
  assign lat_exp = pending && lat_q != '0 && lcnt_q >= lat_q && !upd;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= SOSG_IDLE;
      evt_q <= '0;
    end else begin
      unique case (st_q)
        SOSG_IDLE: begin
          if (sync_event) begin
            st_q <= SOSG_WAIT;
            evt_q <= local_time;
          end
        end
        SOSG_WAIT: begin
          if (sync_event) begin
            evt_q <= local_time;
          end else if (upd || lat_exp || ccr_switch) begin
            st_q <= SOSG_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ldiv_q <= '0;
      lcnt_q <= '0;
    end else if (sync_event) begin
      ldiv_q <= '0;
      lcnt_q <= '0;
    end else if (ldiv_q == LD_W'(LAT_TICK_CYC - 1)) begin
      ldiv_q <= '0;
      if (lcnt_q != '1) lcnt_q <= lcnt_q + 1'b1;
    end else begin
      ldiv_q <= ldiv_q + 1'b1;
    end
  end

  logic [TW-1:0] off, thr;
  logic init_q, skip_q, first_q, err_q;
  logic mag_trip, lock_trip, trip, acc, init_go;
  assign off = {thi_q, tlo_q} + {{(TW - OFS_W){ofs_q[OFS_W-1]}}, ofs_q} - evt_q;
  assign thr = TW'(mag_q) << MAG_SHIFT;
  assign mag_trip = init_q && mag_q != '0 && !skip_q && f_abs(off) > thr;
  assign lock_trip = init_q && !ccdpll_locked && !byp_q;
  assign trip = (upd && (!pending || mag_trip || lock_trip)) || lat_exp;
  assign acc = upd && pending && !trip && init_q;
  assign init_go = upd && pending && !init_q && sysclk_pll_stable;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      init_q <= 1'b0;
    end else if (init_go) begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      err_q <= 1'b0;
    end else if (trip) begin
      err_q <= 1'b1;
    end else if (acc || init_go) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      skip_q <= 1'b1;
    end else if (wr_rst || init_go) begin
      skip_q <= 1'b1;
    end else if (upd && pending) begin
      skip_q <= 1'b0;
    end
  end

  // Refinement: shift grows per accepted offset up to the deepest level
  logic [TW-1:0] filt_q;
  logic [LVL_W-1:0] lvl_q;
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      filt_q <= '0;
      lvl_q <= '0;
      first_q <= 1'b1;
    end else if (init_go) begin
      filt_q <= off;
      lvl_q <= LVL_W'(1);
      first_q <= 1'b0;
    end else if (!init_q) begin
      filt_q <= '0;
      lvl_q <= '0;
      first_q <= 1'b1;
    end else if (wr_rst) begin
      first_q <= 1'b1;
      lvl_q <= '0;
    end else if (acc) begin
      first_q <= 1'b0;
      if (first_q) begin
        filt_q <= off;
      end else begin
        filt_q <= filt_q + TW'($signed(off - filt_q) >>> lvl_q);
      end
      if (lvl_q != LVL_W'(FILT_LEVELS)) lvl_q <= lvl_q + 1'b1;
    end
  end

  // Slew limiter; the tick restarts on a new limit, which is the brief stall
  logic [TW-1:0] app_q, diff, step;
  logic [TK_W-1:0] tk_q;
  logic slewing, slew_prev_q, tick;
  assign diff = filt_q - app_q;
  assign step = TW'(slew_q);
  assign tick = tk_q == TK_W'(SLEW_TICK - 1);
  assign slewing = init_q && slew_q != '0 && app_q != filt_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tk_q <= '0;
    end else if (wr_slew || tick) begin
      tk_q <= '0;
    end else begin
      tk_q <= tk_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      app_q <= '0;
    end else if (init_go) begin
      app_q <= off;
    end else if (!init_q) begin
      app_q <= '0;
    end else if (slew_q == '0) begin
      app_q <= filt_q;
    end else if (tick && !wr_slew) begin
      if (f_abs(diff) <= step) begin
        app_q <= filt_q;
      end else if (diff[TW-1]) begin
        app_q <= app_q - step;
      end else begin
        app_q <= app_q + step;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      common_time <= '0;
    end else begin
      common_time <= local_time + app_q;
    end
  end

  // Sticky flags clear on read; a same-cycle event keeps its flag set
  logic [3:0] irq_q, irq_set;
  logic rd_irq;
  logic init_prev_q;
  assign rd_irq = rd_en && addr == A_IRQ;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_RDY] = init_q && !init_prev_q;
    irq_set[IRQ_ERR] = trip;
    irq_set[IRQ_SST] = slewing && !slew_prev_q;
    irq_set[IRQ_SEND] = !slewing && slew_prev_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= '0;
      slew_prev_q <= 1'b0;
      init_prev_q <= 1'b0;
    end else begin
      slew_prev_q <= slewing;
      init_prev_q <= init_q;
      irq_q <= (rd_irq ? 4'h0 : irq_q) | irq_set;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mfp_slewing <= 1'b0;
      mfp_sync_error <= 1'b0;
      mfp_ready <= 1'b0;
    end else begin
      mfp_slewing <= slewing;
      mfp_sync_error <= trip || err_q;
      mfp_ready <= init_q;
    end
  end

  logic [DW-1:0] rd_d;
  always_comb begin
    rd_d = '0;
    unique case (addr)
      A_OFS: rd_d = ofs_q;
      A_SLEW: rd_d = DW'(slew_q);
      A_LAT: rd_d = DW'(lat_q);
      A_MAG: rd_d = DW'(mag_q);
      A_BYP: rd_d[BYP_BIT] = byp_q;
      A_TLO: rd_d = tlo_q;
      A_THI: rd_d = thi_q;
      A_STAT: begin
        rd_d[ST_ERR] = err_q;
        rd_d[ST_SLEW] = slewing;
        rd_d[ST_RDY] = init_q;
      end
      A_IRQ: rd_d = DW'(irq_q);
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? rd_d : '0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_wait_expire;
    pending && lat_q != '0 && lcnt_q >= lat_q && !upd;
  endsequence

  sequence s_clean_update;
    upd && pending && init_q && (ccdpll_locked || byp_q);
  endsequence

  first_pass_a: assert property (acc && first_q |=> filt_q == $past(off))
    else $error("first offset after restart was filtered");
  mag_off_a: assert property (s_clean_update and (mag_q == '0) |=> !err_q)
    else $error("magnitude check active with zero threshold");
  mag_trip_a: assert property (upd && mag_trip |=> err_q && filt_q == $past(filt_q))
    else $error("oversized offset reached the filter");
  mag_skip_a: assert property (s_clean_update and skip_q |=> !err_q)
    else $error("magnitude check not skipped");
  lat_trip_a: assert property (s_wait_expire and !sync_event |=> err_q && st_q == SOSG_IDLE)
    else $error("late event not discarded");
  slew_byp_a: assert property (init_q && slew_q == '0 && !init_go |=> app_q == $past(filt_q))
    else $error("zero limit did not bypass limiter");
  init_pass_a: assert property (init_go |=> app_q == $past(off) ##1 mfp_ready)
    else $error("initial offset not applied at once");
  slew_irq_a: assert property ($rose(slewing) |=> irq_q[IRQ_SST] ##1 mfp_slewing || !slewing)
    else $error("slew start flag missing");
  restart_a: assert property (wr_rst && init_q |=> first_q && lvl_q == '0 && filt_q == $past(filt_q))
    else $error("restart mishandled");
  slew_stall_a: assert property (wr_slew && init_q && slew_q != '0 |=> app_q == $past(app_q))
    else $error("limiter moved during limit change");
  unlock_a: assert property (upd && pending && init_q && !ccdpll_locked && !byp_q |=> err_q)
    else $error("unlock did not trip guard");
  pre_init_a: assert property (!init_q && !$past(init_go) |-> app_q == '0 && filt_q == '0)
    else $error("pipeline active before initial sync");
  flush_a: assert property (ccr_switch && !sync_event |=> st_q == SOSG_IDLE)
    else $error("switchover kept captured event");
  sum_a: assert property (rst_n_q |=> common_time == $past(local_time) + $past(app_q))
    else $error("common time sum wrong");
endmodule : sosg_top

// [testbench/tb_sosg_top.sv]
`timescale 1ns/10ps
module tb_sosg_top;
  import sosg_pkg::*;
  localparam logic [63:0] LT = 64'h0000_0100_0000_0000;
  localparam logic [63:0] T0 = 64'h0000_0200_0000_0000;
  typedef struct packed {logic [AW-1:0] a; logic [DW-1:0] w; logic [DW-1:0] r;} sosg_row_t;
  logic ref_clk = 1'b0;
  logic resetn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [DW-1:0] rd_data;
  logic sync_event;
  logic [TW-1:0] local_time;
  logic sysclk_pll_stable;
  logic ccdpll_locked;
  logic ccr_switch;
  logic [TW-1:0] common_time;
  logic mfp_slewing;
  logic mfp_sync_error;
  logic mfp_ready;
  int err_count = 0;
  int num_checks = 0;
  int n;
  logic [31:0] rv;
  logic [63:0] ct;
  sosg_row_t rows [13] = '{
    '{A_OFS, 32'h00d6bf95, 32'h00d6bf95}, '{A_SLEW, 32'h00002844, 32'h00002844},
    '{A_LAT, 32'h00000042, 32'h00000042}, '{A_MAG, 32'h00002af3, 32'h00002af3},
    '{A_BYP, 32'h00000001, 32'h00000001}, '{A_RST, 32'h00000001, 32'h00000000},
    '{A_STAT, 32'h000000ff, 32'h00000000}, '{A_IRQ, 32'h000000ff, 32'h00000000},
    '{16'h0d50, 32'h5a5a5a5a, 32'h00000000}, '{A_SLEW, 32'h00000000, 32'h00000000},
    '{A_LAT, 32'h00000000, 32'h00000000}, '{A_MAG, 32'h00000000, 32'h00000000},
    '{A_BYP, 32'h00000000, 32'h00000000}};

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Short slew tick keeps a ramp to a few dozen cycles
  sosg_top #(.FILT_LEVELS(FILT_MAX), .SLEW_TICK(8)) i_sosg_top (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .sync_event(sync_event), .local_time(local_time),
    .sysclk_pll_stable(sysclk_pll_stable), .ccdpll_locked(ccdpll_locked), .ccr_switch(ccr_switch),
    .common_time(common_time), .mfp_slewing(mfp_slewing), .mfp_sync_error(mfp_sync_error),
    .mfp_ready(mfp_ready));

  task print_verdict;
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task chk_bus(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t register read %h expected %h", $time, g, e);
    end
  endtask : chk_bus

  task chk_out(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t output %h expected %h", $time, g, e);
    end
  endtask : chk_out

  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [AW-1:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  task ev;
    @(posedge ref_clk);
    sync_event <= 1'b1;
    @(posedge ref_clk);
    sync_event <= 1'b0;
  endtask : ev

  // Time is written low half first; the update strobe pairs it with the pending event
  task upd(input logic [63:0] t);
    wr(A_TLO, t[31:0]);
    wr(A_THI, t[63:32]);
    wr(A_UPD, 32'h1);
    cyc(3);
    #1 ct = common_time;
  endtask : upd

  task sync(input logic [63:0] t);
    ev();
    upd(t);
  endtask : sync

  initial begin
    resetn = 1'b0;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    sync_event = 1'b0;
    local_time = LT;
    sysclk_pll_stable = 1'b0;
    ccdpll_locked = 1'b1;
    ccr_switch = 1'b0;
    cyc(12);
    #1 chk_out(64'({mfp_slewing, mfp_sync_error, mfp_ready}), 64'h0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk_bus(rv, rows[i].r);
    end
    // Update with nothing captured before initial sync
    upd(64'h10);
    chk_out(64'(mfp_sync_error), 64'h1);
    chk_out(64'(mfp_ready), 64'h0);
    sync(64'h10);
    chk_out(64'(mfp_ready), 64'h0);
    sysclk_pll_stable <= 1'b1;
    sync(T0);
    chk_out(ct, T0 + 64'h00d6bf95);
    chk_out(64'({mfp_ready, mfp_sync_error}), 64'h2);
    rd(A_STAT);
    chk_bus(rv, 32'h4);
    rd(A_IRQ);
    chk_bus(rv & 32'h3, 32'h3);
    rd(A_IRQ);
    chk_bus(rv, 32'h0);
    wr(A_OFS, 32'hffffff00);
    wr(A_RST, 32'h1);
    sync(T0);
    chk_out(ct, T0 - 64'd256);
    // Restart must not bypass the limiter: a 64 step ramps at 16 per tick
    wr(A_SLEW, 32'd16);
    wr(A_RST, 32'h1);
    sync(T0 + 64'd64);
    chk_out(64'(mfp_slewing), 64'h1);
    rd(A_STAT);
    chk_bus(rv & 32'h40, 32'h40);
    for (n = 0; n < 200 && mfp_slewing !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 200) begin
      err_count++;
      $display("BAD %0t slew ramp did not end", $time);
      print_verdict();
    end
    chk_out(64'(n >= 16 && n <= 40), 64'h1);
    #1 chk_out(common_time, T0 - 64'd192);
    rd(A_IRQ);
    chk_bus(rv & 32'hc, 32'hc);
    wr(A_SLEW, 32'h0);
    ccdpll_locked <= 1'b0;
    sync(T0 + 64'd500);
    chk_out(64'(mfp_sync_error), 64'h1);
    chk_out(ct, T0 - 64'd192);
    rd(A_STAT);
    chk_bus(rv & 32'h80, 32'h80);
    rd(A_IRQ);
    chk_bus(rv & 32'h2, 32'h2);
    wr(A_BYP, 32'h1);
    wr(A_RST, 32'h1);
    sync(T0 + 64'd500);
    chk_out({ct[62:0], mfp_sync_error}, {T0[62:0] + 63'd244, 1'b0});
    // Threshold 1 means 256 in offset units; first event after restart skips it
    ccdpll_locked <= 1'b1;
    wr(A_OFS, 32'h0);
    wr(A_MAG, 32'h1);
    wr(A_RST, 32'h1);
    sync(LT + 64'd1000);
    chk_out({ct[62:0], mfp_sync_error}, {LT[62:0] + 63'd1000, 1'b0});
    sync(LT + 64'd1000);
    chk_out({ct[62:0], mfp_sync_error}, {LT[62:0] + 63'd1000, 1'b1});
    sync(LT + 64'd200);
    chk_out(64'(mfp_sync_error), 64'h0);
    chk_out(64'(ct > LT + 64'd200 && ct < LT + 64'd1000), 64'h1);
    // Latency of 1 is 762 cycles at this clock
    wr(A_MAG, 32'h0);
    wr(A_LAT, 32'h1);
    ev();
    cyc(700);
    #1 chk_out(64'(mfp_sync_error), 64'h0);
    cyc(100);
    #1 chk_out(64'(mfp_sync_error), 64'h1);
    upd(LT + 64'd200);
    chk_out(64'(mfp_sync_error), 64'h1);
    sync(LT + 64'd200);
    chk_out(64'(mfp_sync_error), 64'h0);
    wr(A_LAT, 32'h0);
    ev();
    @(posedge ref_clk);
    ccr_switch <= 1'b1;
    @(posedge ref_clk);
    ccr_switch <= 1'b0;
    upd(LT + 64'd900);
    chk_out(64'(mfp_sync_error), 64'h1);
    chk_out(64'(mfp_ready), 64'h1);
    sync(LT + 64'd200);
    chk_out(64'(mfp_sync_error), 64'h0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    cyc(2);
    #1 chk_out({common_time[62:0], mfp_ready}, 64'h0);
    print_verdict();
  end
endmodule : tb_sosg_top
